// ===== logic/dqs_dll_phase_shift.sv
// Read-strobe phase shift: loop up/down counter, offset adder,
// latched per-strobe delay settings, four-element strobe delay and
// postamble gating, with an Avalon-MM slave for control and status.
// Assumes one 20 MHz clock; reference, comparator, reset pin and strobes
// arrive asynchronously and are synchronised here.
//
// What this block does
// - Loop tracks reference period, 100 to 233 MHz
// - Up to 256 reference cycles before valid
// - Below 100 MHz, fixed 2.5 ns delay in mode 0; other modes clamp it to 1F
// - Mode 0 six-bit setting, modes 1-2 five-bit
// - Reference runs through up to 16 elements
// - Comparator direction steps six-bit up/down counter
// - Zero shift bypasses loop and strobe block
// - Setting to strobes or fabric; offset strobes only
// - Offset module adds or subtracts signed offset
// - Offset range -64..63 mode 0, else -32..31
// - Offset static or dynamic with add/subtract select
// - Each strobe pin has own logic block
// - Four elements; first uses setting or sum
// - Strobe setting from loop or fabric
// - Element delay is intrinsic plus steps times step
// - Settings latched together on update enable
// - Update enable refreshes every 8 clocks
// - Shifted strobe clocks capture, also to fabric
// - Postamble gating forces shifted strobe low
// - Shifts are multiples of 22.5, 30 or 36 degrees
`timescale 1ns/1ps
`default_nettype none
`include "dqs_phase_cfg.svh"

module dqs_dll_phase_shift #(
  parameter int STEP_PS = `STEP_PS_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ref_clk_pin,
  input wire logic cmp_up_pin,
  input wire logic dll_reset_pin,
  input wire logic [5:0] dll_offset,
  input wire logic addnsub,
  input wire logic [`SET_W-1:0] fabric_setting,
  input wire dqs_phase_pkg::strobe_vec_type strobe_pin,
  input wire dqs_phase_pkg::strobe_vec_type read_window,
  output dqs_phase_pkg::strobe_vec_type strobe_out,
  output dqs_phase_pkg::setting_vec_type chain_setting,
  output logic update_en,
  output logic [`SET_W-1:0] fabric_delay_out,
  output logic dll_ready
);

  localparam logic [`SET_W-1:0] LOW_FREQ_SET = `SET_W'(`LOW_FREQ_DELAY_PS / STEP_PS);

  dqs_phase_pkg::state_type s_q;
  dqs_phase_pkg::state_type s_d;

  logic ref_tick;
  logic dll_rst;
  logic [`SET_W-1:0] set_max;
  logic [`SET_W-1:0] base_set;
  logic [`SUM_W-1:0] ofs_raw;
  logic [`SUM_W-1:0] ofs_clamp;
  logic [`SUM_W-1:0] sum_raw;
  logic [`SET_W-1:0] sum_set;
  logic [`CTRL_MODE_W-1:0] mode;

  // Rising edge of the synchronised reference; the first sync stage is left alone
  assign ref_tick = s_q.ref_sync[1] & ~s_q.ref_sync[2];
  assign dll_rst = s_q.rst_sync[1] | s_q.ctrl[`CTRL_SOFT_RST];
  // Frequency mode field of the control word
  assign mode = s_q.ctrl[`CTRL_MODE_LO +: `CTRL_MODE_W];

  // Mode range, low-frequency fixed delay and signed offset
  always_comb begin
    set_max = (mode == `MODE0) ? `SET_MAX_M0 : `SET_MAX_M12;
    base_set = s_q.ctrl[`CTRL_LOW_FREQ] ? LOW_FREQ_SET : s_q.loop_set;
    if (base_set > set_max) begin
      base_set = set_max;
    end
    // Dynamic offset picks direction from addnsub only when enabled to
    if (s_q.ctrl[`CTRL_DYN_EN]) begin
      if (s_q.ctrl[`CTRL_DYN_ADDNSUB] ? !addnsub : s_q.ctrl[`CTRL_DYN_SUB]) begin
        ofs_raw = `SUM_W'(-{2'b00, dll_offset});
      end else begin
        ofs_raw = {2'b00, dll_offset};
      end
    end else begin
      ofs_raw = {s_q.static_ofs[`OFS_W-1], s_q.static_ofs};
    end
    ofs_clamp = ofs_raw;
    if (mode == `MODE0) begin
      if ($signed(ofs_raw) > $signed(`OFS_MAX_M0)) begin
        ofs_clamp = `OFS_MAX_M0;
      end else if ($signed(ofs_raw) < $signed(`OFS_MIN_M0)) begin
        ofs_clamp = `OFS_MIN_M0;
      end
    end else begin
      if ($signed(ofs_raw) > $signed(`OFS_MAX_M12)) begin
        ofs_clamp = `OFS_MAX_M12;
      end else if ($signed(ofs_raw) < $signed(`OFS_MIN_M12)) begin
        ofs_clamp = `OFS_MIN_M12;
      end
    end
    sum_raw = {2'b00, base_set} + ofs_clamp;
    // Saturate so a large subtract never wraps to a long delay
    if (sum_raw[`SUM_W-1]) begin
      sum_set = '0;
    end else if (sum_raw > {2'b00, set_max}) begin
      sum_set = set_max;
    end else begin
      sum_set = sum_raw[`SET_W-1:0];
    end
  end

  // Next-state of the whole block
  always_comb begin
    logic [`SET_W-1:0] src;
    logic [`TAPS_W-1:0] taps;
    logic bypass;
    src = '0;
    taps = '0;
    bypass = 1'b0;
    s_d = s_q;
    s_d.ref_sync = {s_q.ref_sync[1:0], ref_clk_pin};
    s_d.cmp_sync = {s_q.cmp_sync[0], cmp_up_pin};
    s_d.rst_sync = {s_q.rst_sync[0], dll_reset_pin};
    s_d.strb_sync = {s_q.strb_sync[0], strobe_pin};

    // Loop: comparator direction steps the setting once per reference edge
    if (dll_rst) begin
      s_d.loop_set = '0;
      s_d.lock_cnt = '0;
      s_d.restart_cnt = '0;
      s_d.stopped = 1'b0;
      s_d.idle_cnt = '0;
    end else if (ref_tick) begin
      // Setting drives a chain of up to 16 elements; counter closes phase
      if (s_q.cmp_sync[1]) begin
        if (s_q.loop_set < set_max) begin
          s_d.loop_set = s_q.loop_set + `SET_W'(1);
        end
      end else if (s_q.loop_set != '0) begin
        s_d.loop_set = s_q.loop_set - `SET_W'(1);
      end
      if (s_q.loop_set > set_max) begin
        s_d.loop_set = set_max;
      end
      if (s_q.lock_cnt != `LOCK_REF_CYC) begin
        s_d.lock_cnt = s_q.lock_cnt + 9'd1;
      end
      if (s_q.restart_cnt != `RESTART_REF_CYC) begin
        s_d.restart_cnt = s_q.restart_cnt + 9'd1;
      end
      s_d.idle_cnt = '0;
      s_d.stopped = 1'b0;
    end else if (s_q.idle_cnt == `STOP_CLK_CYC) begin
      // Reference stood still: demand fresh settling once it returns
      s_d.stopped = 1'b1;
      s_d.restart_cnt = '0;
    end else begin
      s_d.idle_cnt = s_q.idle_cnt + 8'd1;
    end
    s_d.dll_ready = !dll_rst && !s_d.stopped && s_d.lock_cnt == `LOCK_REF_CYC
                    && s_d.restart_cnt == `RESTART_REF_CYC;

    // Update enable pulse every eighth clock
    s_d.upd_cnt = s_q.upd_cnt + 3'd1;
    s_d.update_en = (s_q.upd_cnt == `UPD_PERIOD);

    // Fabric sees the setting without offset
    s_d.fabric_delay = base_set;

    // Per-strobe blocks: latched setting and four delay elements
    for (int i = 0; i < `NUM_STROBES; i++) begin
      bypass = s_q.strb_cfg[`STRB_BYPASS_LO + i];
      taps = s_q.strb_cfg[`STRB_TAPS_LO + `TAPS_W * i +: `TAPS_W];
      if (s_q.strb_cfg[`STRB_SRC_FAB_LO + i]) begin
        src = (fabric_setting > set_max) ? set_max : fabric_setting;
      end else if (s_q.strb_cfg[`STRB_USE_OFS_LO + i]) begin
        src = sum_set;
      end else begin
        src = base_set;
      end
      // All blocks load together so no element sees a half-travelled value
      if (s_q.update_en) begin
        s_d.chain_set[i] = bypass ? '0 : src;
      end
      // Each element is one stage; taps picks 1..4 elements, giving
      // multiples of the mode's unit angle
      s_d.strb_pipe[i] = {s_q.strb_pipe[i][2:0], s_q.strb_sync[1][i]};
      if (!read_window[i]) begin
        s_d.strobe_out[i] = 1'b0;
      end else if (bypass) begin
        s_d.strobe_out[i] = s_q.strb_sync[1][i];
      end else begin
        s_d.strobe_out[i] = s_q.strb_pipe[i][taps];
      end
    end

    // Avalon slave: one wait cycle, then the request is taken
    s_d.waitrequest = !((read || write) && s_q.waitrequest);
    // Read data is captured while the request still waits
    if (read && s_q.waitrequest) begin
      if (address == `ADDR_CTRL) begin
        s_d.readdata = {25'h0, s_q.ctrl};
      end else if (address == `ADDR_OFFSET) begin
        s_d.readdata = {{25{s_q.static_ofs[`OFS_W-1]}}, s_q.static_ofs};
      end else if (address == `ADDR_STATUS) begin
        s_d.readdata = '0;
        s_d.readdata[`STAT_LOCKED] = s_q.lock_cnt == `LOCK_REF_CYC;
        s_d.readdata[`STAT_READY] = s_q.dll_ready;
        s_d.readdata[`STAT_STOPPED] = s_q.stopped;
        s_d.readdata[`STAT_SET_LO +: `SET_W] = base_set;
        s_d.readdata[`STAT_SUM_LO +: `SET_W] = sum_set;
      end else if (address == `ADDR_STROBE) begin
        s_d.readdata = s_q.strb_cfg;
      end else begin
        s_d.readdata = '0;
      end
    end
    // Writes land only on the edge that answers the request
    if (write && !s_q.waitrequest) begin
      if (address == `ADDR_CTRL) begin
        s_d.ctrl = writedata[6:0];
      end else if (address == `ADDR_OFFSET) begin
        s_d.static_ofs = writedata[`OFS_W-1:0];
      end else if (address == `ADDR_STROBE) begin
        s_d.strb_cfg = writedata & `STRB_WR_MASK;
      end
    end
  end

  // Single state register; async reset loads constants only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl <= `CTRL_RESET;
      s_q.strb_cfg <= `STRB_RESET;
      s_q.waitrequest <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.readdata;
  assign waitrequest = s_q.waitrequest;
  assign strobe_out = s_q.strobe_out;
  assign chain_setting = s_q.chain_set;
  assign update_en = s_q.update_en;
  assign fabric_delay_out = s_q.fabric_delay;
  assign dll_ready = s_q.dll_ready;

  // Checks on the design's own outputs and internal state
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bus_answer;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no answer after one wait");

  property p_bus_release;
    !waitrequest |=> waitrequest;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("waitrequest low twice");

  property p_wait_idle;
    !read && !write |=> waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low unasked");

  property p_update_period;
    update_en |=> !update_en [*7] ##1 update_en;
  endproperty
  a_update_period: assert property (p_update_period) else $error("update period not 8");

  property p_latch_hold;
    !$past(update_en) |-> $stable(chain_setting);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("setting moved off update");

  property p_sat_max;
    (mode != `MODE0) && $past(mode != `MODE0, 9)
      |-> chain_setting[0] <= `SET_MAX_M12;
  endproperty
  a_sat_max: assert property (p_sat_max) else $error("setting above mode range");

  property p_lock_wait;
    dll_ready |-> s_q.lock_cnt == `LOCK_REF_CYC;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("ready before lock count");

  property p_stop_drop;
    $rose(s_q.stopped) |-> !dll_ready;
  endproperty
  a_stop_drop: assert property (p_stop_drop) else $error("ready kept after stop");

  property p_postamble;
    strobe_out[0] |-> $past(read_window[0]);
  endproperty
  a_postamble: assert property (p_postamble) else $error("strobe passed outside window");

  property p_bypass;
    s_q.strb_cfg[`STRB_BYPASS_LO] && $past(s_q.strb_cfg[`STRB_BYPASS_LO]) && $past(read_window[0])
      |-> strobe_out[0] == $past(s_q.strb_sync[1][0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path delayed");

  property p_step_up;
    ref_tick && s_q.cmp_sync[1] && !dll_rst && s_q.loop_set < set_max
      |=> s_q.loop_set == $past(s_q.loop_set) + `SET_W'(1);
  endproperty
  a_step_up: assert property (p_step_up) else $error("counter did not step up");

  // Loop counter and readiness
  property p_step_down;
    ref_tick && !s_q.cmp_sync[1] && !dll_rst && s_q.loop_set != '0 && s_q.loop_set <= set_max
      |=> s_q.loop_set == $past(s_q.loop_set) - `SET_W'(1);
  endproperty
  a_step_down: assert property (p_step_down) else $error("counter did not step down");

  property p_rst_ready;
    dll_rst |=> !dll_ready;
  endproperty
  a_rst_ready: assert property (p_rst_ready) else $error("ready kept in loop reset");

  property p_ready_restart;
    dll_ready |-> s_q.restart_cnt == `RESTART_REF_CYC && !s_q.stopped;
  endproperty
  a_ready_restart: assert property (p_ready_restart) else $error("ready before restart");

  // Strobe path, fabric outputs and bus read data
  property p_postamble_all;
    (strobe_out & ~$past(read_window)) == '0;
  endproperty
  a_postamble_all: assert property (p_postamble_all) else $error("strobe outside window");

  property p_bypass_set;
    $past(update_en) && $past(s_q.strb_cfg[`STRB_BYPASS_LO]) |-> chain_setting[0] == '0;
  endproperty
  a_bypass_set: assert property (p_bypass_set) else $error("bypass setting not zero");

  property p_low_freq;
    $past(s_q.ctrl[`CTRL_LOW_FREQ]) && $past(mode == `MODE0)
      |-> fabric_delay_out == LOW_FREQ_SET;
  endproperty
  a_low_freq: assert property (p_low_freq) else $error("low-frequency delay wrong");

  property p_read_hold;
    !$past(read) |-> $stable(readdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved unasked");

  c_ready: cover property ($rose(dll_ready));
  c_restart: cover property ($fell(s_q.stopped) ##[1:200] dll_ready);
  c_gated: cover property (strobe_out[0] ##1 !read_window[0] ##1 !strobe_out[0]);
  // Reference halt and bypassed strobe both reached
  c_stopped: cover property ($rose(s_q.stopped));
  c_bypass: cover property (s_q.strb_cfg[`STRB_BYPASS_LO] && strobe_out[0]);

endmodule : dqs_dll_phase_shift

`default_nettype wire

// ===== logic/dqs_phase_cfg.svh
// Constants for the read-strobe phase-shift block: register map,
// field positions, reset values and timing counts.
// Assumes it is included by the package and by the principal module only.
`ifndef DQS_PHASE_CFG_SVH
`define DQS_PHASE_CFG_SVH

// Strobe pins served by one phase-shift circuit
`define NUM_STROBES 4
`define SET_W 6
`define OFS_W 7
`define SUM_W 8

// Register byte offsets
`define ADDR_W 4
`define ADDR_CTRL 4'h0
`define ADDR_OFFSET 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_STROBE 4'hC

// Control register fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_W 2
`define CTRL_LOW_FREQ 2
`define CTRL_DYN_EN 3
`define CTRL_DYN_SUB 4
`define CTRL_DYN_ADDNSUB 5
`define CTRL_SOFT_RST 6
`define CTRL_RESET 7'h00

// Strobe configuration register fields
`define STRB_BYPASS_LO 0
`define STRB_USE_OFS_LO 4
`define STRB_SRC_FAB_LO 8
`define STRB_TAPS_LO 16
`define STRB_RESET 32'h0000_0000
`define STRB_WR_MASK 32'h00FF_0FFF

// Status register fields
`define STAT_LOCKED 0
`define STAT_READY 1
`define STAT_STOPPED 2
`define STAT_SET_LO 8
`define STAT_SUM_LO 16

// Setting ranges per frequency mode
`define MODE0 2'h0
`define SET_MAX_M0 6'h3F
`define SET_MAX_M12 6'h1F
`define OFS_MIN_M0 8'hC0
`define OFS_MAX_M0 8'h3F
`define OFS_MIN_M12 8'hE0
`define OFS_MAX_M12 8'h1F

// Timing figures
`define LOCK_REF_CYC 9'd256
`define RESTART_REF_CYC 9'd16
`define UPD_PERIOD 3'd7
`define STOP_CLK_CYC 8'd64
`define LOW_FREQ_DELAY_PS 2500
`define STEP_PS_DEFAULT 50
`define TAPS_W 2

`endif

// ===== logic/dqs_phase_pkg.sv
// Types for the read-strobe phase-shift block.
// Assumes dqs_phase_cfg.svh supplies the sizes.
`default_nettype none
`include "dqs_phase_cfg.svh"

package dqs_phase_pkg;

  typedef logic [`NUM_STROBES-1:0] strobe_vec_type;
  typedef logic [`NUM_STROBES-1:0][`SET_W-1:0] setting_vec_type;

  // Whole state of the block, registered in one process
  typedef struct packed {
    logic [2:0] ref_sync;
    logic [1:0] cmp_sync;
    logic [1:0] rst_sync;
    logic [1:0][`NUM_STROBES-1:0] strb_sync;
    logic [6:0] ctrl;
    logic [`OFS_W-1:0] static_ofs;
    logic [31:0] strb_cfg;
    logic [`SET_W-1:0] loop_set;
    logic [8:0] lock_cnt;
    logic [8:0] restart_cnt;
    logic [7:0] idle_cnt;
    logic stopped;
    logic dll_ready;
    logic [2:0] upd_cnt;
    logic update_en;
    setting_vec_type chain_set;
    logic [`NUM_STROBES-1:0][3:0] strb_pipe;
    strobe_vec_type strobe_out;
    logic [`SET_W-1:0] fabric_delay;
    logic waitrequest;
    logic [31:0] readdata;
  } state_type;

endpackage : dqs_phase_pkg

`default_nettype wire

// ===== tb/dqs_dll_phase_shift_test.sv
// Self-checking bench for the read-strobe phase-shift block.
// Assumes the memory-side model and a 20 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

module dqs_dll_phase_shift_test;
  logic clk, rst_n, read, write, waitrequest, cmp_up_pin, dll_reset_pin;
  logic addnsub, run, burst, ref_clk_pin, update_en, dll_ready;
  logic [3:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [5:0] dll_offset, fabric_setting, fabric_delay_out;
  dqs_phase_pkg::strobe_vec_type read_window, strobe_pin, strobe_out;
  dqs_phase_pkg::setting_vec_type chain_setting;
  int num_errors, n_tests, c;

  dqs_dll_phase_shift dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ref_clk_pin(ref_clk_pin), .cmp_up_pin(cmp_up_pin), .dll_reset_pin(dll_reset_pin),
    .dll_offset(dll_offset), .addnsub(addnsub), .fabric_setting(fabric_setting),
    .strobe_pin(strobe_pin), .read_window(read_window), .strobe_out(strobe_out),
    .chain_setting(chain_setting), .update_en(update_en),
    .fabric_delay_out(fabric_delay_out), .dll_ready(dll_ready));

  sdram_strobe_model mem (.run(run), .burst(burst), .ref_clk(ref_clk_pin),
    .strobe(strobe_pin));

  // 50 ns period
  always #25 clk = ~clk;

  task conclude;
    $display("%0d checks, %0d errors", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task fail_out;
    num_errors++;
    $display("ERROR %0t: wait ran out", $time);
    conclude();
  endtask : fail_out

  task wclk(input int n);
    repeat (n) @(posedge clk);
  endtask : wclk

  // One bus word; a request is held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) fail_out();
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task stat;
    wclk(2);
    bus(1'b0, 4'h8, 32'h0);
  endtask : stat

  task wait_ready;
    for (c = 0; c < 4000; c++) begin
      @(posedge clk);
      if (dll_ready === 1'b1) break;
    end
    if (c == 4000) fail_out();
  endtask : wait_ready

  logic [3:0] c_addr [4] = '{4'h0, 4'h4, 4'hC, 4'h2};

  task t_regs;
    check(waitrequest, 1'b1);
    check(dll_ready, 1'b0);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    foreach (c_addr[k]) begin
      bus(1'b0, c_addr[k], 32'h0);
      check(rd, 32'h0);
    end
    $display("done regs");
  endtask : t_regs

  task t_update;
    for (c = 0; c < 20; c++) begin
      @(posedge clk);
      if (update_en === 1'b1) break;
    end
    for (c = 1; c < 20; c++) begin
      @(posedge clk);
      if (update_en === 1'b1) break;
    end
    check(c, 8);
    $display("done update");
  endtask : t_update

  task t_lock;
    wait_ready();
    stat();
    check(rd[13:8], 6'h3F);
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, 4'h0, m);
      wclk(400);
      stat();
      check(rd[13:8], 6'h1F);
    end
    cmp_up_pin <= 1'b0;
    wclk(400);
    stat();
    check(rd[13:8], 6'h0);
    cmp_up_pin <= 1'b1;
    bus(1'b1, 4'h0, 32'h0);
    wclk(800);
    stat();
    check(rd[13:8], 6'h3F);
    $display("done lock");
  endtask : t_lock

  // Base setting is 3F here; sums must clamp, not wrap
  task t_offset;
    bus(1'b1, 4'h4, 32'h7F);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'hFFFF_FFFF);
    stat();
    check(rd[21:16], 6'h3E);
    bus(1'b1, 4'h4, 32'h40);
    stat();
    check(rd[21:16], 6'h0);
    bus(1'b1, 4'h4, 32'h3F);
    stat();
    check(rd[21:16], 6'h3F);
    dll_offset <= 6'h05;
    addnsub <= 1'b0;
    bus(1'b1, 4'h0, 32'h28);
    stat();
    check(rd[21:16], 6'h3A);
    addnsub <= 1'b1;
    stat();
    check(rd[21:16], 6'h3F);
    dll_offset <= 6'h02;
    bus(1'b1, 4'h0, 32'h18);
    stat();
    check(rd[21:16], 6'h3D);
    bus(1'b1, 4'h0, 32'h0);
    $display("done offset");
  endtask : t_offset

  task t_chain;
    bus(1'b1, 4'h4, 32'h7F);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    check(rd, 32'h00FF_0FFF);
    bus(1'b1, 4'hC, 32'h0000_0410);
    wclk(17);
    check(chain_setting[0], 6'h3E);
    check(chain_setting[1], 6'h3F);
    check(chain_setting[2], 6'h15);
    check(fabric_delay_out, 6'h3F);
    bus(1'b1, 4'h0, 32'h4);
    wclk(4);
    check(fabric_delay_out, 6'h32);
    bus(1'b1, 4'h0, 32'h0);
    $display("done chain");
  endtask : t_chain

  task t_strobe;
    dqs_phase_pkg::strobe_vec_type acc;
    bus(1'b1, 4'hC, 32'h00E4_0009);
    acc = 4'h0;
    wclk(3);
    repeat (40) begin
      @(posedge clk);
      acc = acc | strobe_out;
    end
    check(acc, 4'h0);
    burst <= 1'b1;
    read_window <= 4'hF;
    wclk(5);
    repeat (40) begin
      @(posedge clk);
      acc = acc | strobe_out;
    end
    check(acc, 4'hF);
    burst <= 1'b0;
    read_window <= 4'h0;
    $display("done strobe");
  endtask : t_strobe

  // Controller waits out relock and restart before trusting data
  task t_restart;
    bus(1'b1, 4'h0, 32'h40);
    stat();
    check(rd[13:8], 6'h0);
    check(rd[1], 1'b0);
    bus(1'b1, 4'h0, 32'h0);
    dll_reset_pin <= 1'b1;
    wclk(4);
    check(dll_ready, 1'b0);
    stat();
    check(rd[13:8], 6'h0);
    dll_reset_pin <= 1'b0;
    wait_ready();
    check(c >= 2540 && c <= 2700, 1'b1);
    run <= 1'b0;
    wclk(100);
    stat();
    check(rd[2:1], 2'b10);
    run <= 1'b1;
    wait_ready();
    check(c >= 140 && c <= 200, 1'b1);
    $display("done restart");
  endtask : t_restart

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    cmp_up_pin = 1'b1;
    dll_reset_pin = 1'b0;
    dll_offset = 6'h00;
    addnsub = 1'b0;
    fabric_setting = 6'h15;
    read_window = 4'h0;
    run = 1'b1;
    burst = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_update();
    t_lock();
    t_offset();
    t_chain();
    t_strobe();
    t_restart();
    conclude();
  end
endmodule : dqs_dll_phase_shift_test

`default_nettype wire

// ===== tb/sdram_strobe_model.sv
// Memory-side model: slowed reference clock and four read strobes.
// Assumes the bench drives run and burst; delays in ns.
`timescale 1ns/1ps
`default_nettype none

module sdram_strobe_model (
  input wire logic run,
  input wire logic burst,
  output logic ref_clk,
  output dqs_phase_pkg::strobe_vec_type strobe
);
  logic tog;
  logic [3:0] noise;

  // Reference halts while run is low, as around refresh
  initial ref_clk = 1'b0;
  always #250 ref_clk = run ? ~ref_clk : 1'b0;

  // Strobe period matches the reference period
  initial tog = 1'b0;
  always #250 tog = ~tog;

  // Released line floats: bits 3:2 toggle as noise, bits 1:0 keep their last level
  initial noise = 4'h5;
  always #60 noise = ~noise ^ 4'h3;

  assign strobe = burst ? {4{tog}} : noise;
endmodule : sdram_strobe_model

`default_nettype wire
